// ---- logic/ocar_pkg.sv ----
// Shared constants for the overlay character attribute memory
package ocar_pkg;
  // Address map
  localparam int ADDR_W = 12;
  localparam logic [11:0] BASE_ADDR = 12'hd00;
  localparam logic [11:0] LAST_BLOCK_ADDR = 12'hf80;
  localparam int BLOCK_COUNT = 6;
  localparam int CHARS_PER_BLOCK = 32;
  localparam logic [1:0] SEL_CODE = 2'h0;
  localparam logic [1:0] SEL_COLOR1 = 2'h1;
  localparam logic [1:0] SEL_COLOR2 = 2'h2;
  localparam logic [1:0] SEL_HOLE = 2'h3;
  // Field positions inside first color byte
  localparam int C1_CODE_HI = 0;
  localparam int C1_PAL_LO = 1;
  localparam int C1_ITALIC = 4;
  localparam int C1_FLASH = 5;
  localparam int C1_ULINE = 6;
  localparam int C1_LUM2 = 7;
  // Second color byte meaningful width
  localparam int C2_W = 2;
  // Palette constants
  localparam logic [3:0] PAL_TRANSPARENT = 4'h0;
  localparam logic [3:0] PAL_BLACK = 4'h8;
  localparam int PAL_COLORS = 64;
  // Underline rows, counted from zero
  localparam logic [4:0] ULINE_ROW_A = 5'h16;
  localparam logic [4:0] ULINE_ROW_B = 5'h17;
  // Reset values
  localparam logic [31:0] RDATA_RST = 32'h0;
  localparam logic [7:0] MEM_RST = 8'h00;
  // Display modes
  typedef enum logic [1:0] {
    OCAR_CC = 2'b00,
    OCAR_OVL = 2'b01,
    OCAR_CDOT = 2'b11
  } ocar_mode_e;
endpackage : ocar_pkg

// ---- logic/ocar_mem.sv ----
// Dual-port byte memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module ocar_mem #(
  parameter int DEPTH = 192,
  parameter int AW = 8
) (
  // Clock
  input wire logic clk,
  // Write and read port A
  input wire logic a_we,
  input wire logic [AW-1:0] a_addr,
  input wire logic [7:0] a_wdata,
  output logic [7:0] a_rdata,
  // Read port B
  input wire logic [AW-1:0] b_addr,
  output logic [7:0] b_rdata
);
  // Index must reach every stored byte
  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("DEPTH does not fit the address width");
  end

  // Storage, no reset: contents undefined until written
  logic [7:0] mem [DEPTH];

  // Port A write and read
  always_ff @(posedge clk) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    a_rdata <= mem[a_addr];
  end

  // Port B read
  always_ff @(posedge clk) begin
    b_rdata <= mem[b_addr];
  end
endmodule : ocar_mem
`default_nettype wire

// ---- logic/ocar_top.sv ----
// Overlay character attribute memory with APB slave and display decode
`timescale 1ns/1ns
`default_nettype none
module ocar_top
  import ocar_pkg::*;
#(
  parameter int NBLOCKS = 6
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [31:0] PRDATA,
  // Display generator request
  input wire logic [1:0] MODE,
  input wire logic [2:0] BLOCK_SEL,
  input wire logic [4:0] CHAR_SEL,
  input wire logic [4:0] ROW_SEL,
  input wire logic [3:0] DOT_PAL,
  input wire logic CC_PAL_HIGH,
  input wire logic [1:0] CC_BG_RANGE,
  // Decoded attributes
  output logic [8:0] FONT_INDEX,
  output logic [3:0] CHAR_PALETTE,
  output logic [3:0] BG_PALETTE,
  output logic ITALIC,
  output logic FLASH,
  output logic UNDERLINE_ON,
  output logic TRANSPARENT,
  output logic BLACK,
  output logic FIRST_LUMINANCE_OUTPUT,
  output logic SECOND_LUMINANCE_OUTPUT
);
  import ocar_pkg::*;

  // Decode is wired for exactly the six mapped blocks
  if (NBLOCKS != BLOCK_COUNT) begin : g_bad_blocks
    $error("NBLOCKS must equal the mapped block count");
  end

  // Hole rows keep their memory slots so the index is plain wiring
  localparam int MAW = 10;
  localparam int DEPTH = 1 << MAW;

  ////////////////////////////////////////////////////////////////////////
  // APB address decode
  ////////////////////////////////////////////////////////////////////////
  logic [11:0] off; // Offset from first block
  logic [2:0] blk; // Block number 0..5
  logic [1:0] sel; // Row inside block
  logic in_range; // Address lands on a block
  logic hit; // Mapped byte
  logic [MAW-1:0] apb_idx; // Memory index from APB
  assign off = PADDR[11:0] - BASE_ADDR;
  assign blk = off[9:7];
  assign sel = off[6:5];
  assign in_range = (PADDR[31:12] == 20'h0) && (PADDR[11:0] >= BASE_ADDR)
                    && (blk < 3'(NBLOCKS));
  // Holes answer with an error and change nothing
  assign hit = in_range && (sel != SEL_HOLE);
  assign apb_idx = MAW'({blk, sel, off[4:0]});

  logic setup_ph; // Setup cycle seen
  assign setup_ph = PSEL && !PENABLE;

  ////////////////////////////////////////////////////////////////////////
  // APB handshake: access cycle one after setup, then one wait
  ////////////////////////////////////////////////////////////////////////
  logic wait_reg; // Read data pending one cycle
  logic [1:0] rsel_reg; // Row of pending read
  logic rhit_reg; // Pending read is mapped
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      wait_reg <= 1'b0;
      rsel_reg <= SEL_CODE;
      rhit_reg <= 1'b0;
    end else begin
      // Memory read latency forces one wait state
      wait_reg <= setup_ph;
      rsel_reg <= sel;
      rhit_reg <= hit;
    end
  end

  // Write lands only at the completing edge, so an abandoned transfer writes nothing
  logic mem_we; // Memory write strobe
  assign mem_we = PSEL && PENABLE && PREADY && PWRITE && hit;
  logic [7:0] a_rdata;
  logic [7:0] b_rdata;
  logic [MAW-1:0] b_idx;

  // Response registers
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= RDATA_RST;
    end else begin
      PREADY <= wait_reg;
      PSLVERR <= wait_reg && !rhit_reg;
      if (wait_reg) begin
        if (!rhit_reg) begin
          PRDATA <= RDATA_RST;
        end else if (rsel_reg == SEL_COLOR2) begin
          // Upper bits held as written; software must ignore them
          PRDATA <= {24'h0, a_rdata};
        end else begin
          // All bits stored regardless of mode
          PRDATA <= {24'h0, a_rdata};
        end
      end
    end
  end

  // Answers stand one cycle and keep the upper data bits clear
  ready_once_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    PREADY |=> !PREADY)
    else $error("ready held too long");
  err_with_ready_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    PSLVERR |-> PREADY)
    else $error("error without ready");
  rdata_upper_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("read data upper bits set");

  ////////////////////////////////////////////////////////////////////////
  // Display lookup: three rows fetched over three cycles
  ////////////////////////////////////////////////////////////////////////
  logic [1:0] ph_reg; // Fetch phase
  logic [1:0] ph_d_reg; // Phase of data now on b_rdata
  logic [7:0] code_reg;
  logic [7:0] c1_reg;
  logic [7:0] c2_reg;
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ph_reg <= SEL_CODE;
      ph_d_reg <= SEL_CODE;
    end else begin
      ph_reg <= (ph_reg == SEL_COLOR2) ? SEL_CODE : ph_reg + 2'h1;
      ph_d_reg <= ph_reg;
    end
  end
  assign b_idx = MAW'({BLOCK_SEL, ph_reg, CHAR_SEL});

  // Capture fetched bytes
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      code_reg <= MEM_RST;
      c1_reg <= MEM_RST;
      c2_reg <= MEM_RST;
    end else begin
      unique case (ph_d_reg)
        SEL_CODE: code_reg <= b_rdata;
        SEL_COLOR1: c1_reg <= b_rdata;
        SEL_COLOR2: c2_reg <= b_rdata;
        default: code_reg <= code_reg;
      endcase
    end
  end

  ocar_mem #(.DEPTH(DEPTH), .AW(MAW)) u_mem (
    .clk(CLOCK),
    .a_we(mem_we),
    .a_addr(apb_idx),
    .a_wdata(PWDATA[7:0]),
    .a_rdata(a_rdata),
    .b_addr(b_idx),
    .b_rdata(b_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Attribute decode per mode
  ////////////////////////////////////////////////////////////////////////
  logic [8:0] font_next;
  logic [3:0] cpal_next;
  logic [3:0] bpal_next;
  logic ital_next;
  logic flash_next;
  logic ul_next;
  always_comb begin
    font_next = {c1_reg[C1_CODE_HI], code_reg};
    cpal_next = PAL_TRANSPARENT;
    bpal_next = PAL_TRANSPARENT;
    ital_next = 1'b0;
    flash_next = 1'b0;
    ul_next = 1'b0;
    unique case (ocar_mode_e'(MODE))
      OCAR_CC: begin
        cpal_next = {CC_PAL_HIGH, c1_reg[3:1]};
        bpal_next = {CC_BG_RANGE, c2_reg[1:0]};
        ital_next = c1_reg[C1_ITALIC];
        flash_next = c1_reg[C1_FLASH];
        ul_next = c1_reg[C1_ULINE] &&
                  (ROW_SEL == ULINE_ROW_A || ROW_SEL == ULINE_ROW_B);
      end
      OCAR_OVL: begin
        cpal_next = c1_reg[4:1];
        bpal_next = {c2_reg[1:0], c1_reg[6:5]};
      end
      OCAR_CDOT: begin
        font_next = {1'b0, code_reg};
        // Dots on palette 0 or 8 take the per-character palette
        cpal_next = (DOT_PAL == PAL_TRANSPARENT || DOT_PAL == PAL_BLACK)
                    ? c1_reg[6:3] : DOT_PAL;
      end
      default: begin
        // Reserved mode code shows nothing but the font index and the second luminance bit
        cpal_next = PAL_TRANSPARENT;
      end
    endcase
  end

  // Registered outputs
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      FONT_INDEX <= 9'h0;
      CHAR_PALETTE <= PAL_TRANSPARENT;
      BG_PALETTE <= PAL_TRANSPARENT;
      ITALIC <= 1'b0;
      FLASH <= 1'b0;
      UNDERLINE_ON <= 1'b0;
      TRANSPARENT <= 1'b1;
      BLACK <= 1'b0;
      FIRST_LUMINANCE_OUTPUT <= 1'b0;
      SECOND_LUMINANCE_OUTPUT <= 1'b0;
    end else begin
      FONT_INDEX <= font_next;
      CHAR_PALETTE <= cpal_next;
      BG_PALETTE <= bpal_next;
      ITALIC <= ital_next;
      FLASH <= flash_next;
      UNDERLINE_ON <= ul_next;
      TRANSPARENT <= (cpal_next == PAL_TRANSPARENT);
      BLACK <= (cpal_next == PAL_BLACK);
      // Solid luminance while any visible colour is drawn
      FIRST_LUMINANCE_OUTPUT <= (cpal_next != PAL_TRANSPARENT);
      SECOND_LUMINANCE_OUTPUT <= c1_reg[C1_LUM2];
    end
  end

  // Per-mode decode, outputs one cycle behind their inputs
  cc_font_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    MODE == OCAR_CC |=> FONT_INDEX == $past({c1_reg[C1_CODE_HI], code_reg}))
    else $error("caption font index wrong");
  cc_italic_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    MODE == OCAR_CC |=> ITALIC == $past(c1_reg[C1_ITALIC]))
    else $error("italic bit not applied");
  cc_flash_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    MODE == OCAR_CC |=> FLASH == $past(c1_reg[C1_FLASH]))
    else $error("flash bit not applied");
  uline_bit_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    UNDERLINE_ON |-> $past(c1_reg[C1_ULINE]) && $past(MODE) == OCAR_CC)
    else $error("underline without its bit");
  cc_bg_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    MODE == OCAR_CC |=> BG_PALETTE == $past({CC_BG_RANGE, c2_reg[1:0]}))
    else $error("caption background wrong");
  ovl_pal_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    MODE == OCAR_OVL |=> CHAR_PALETTE == $past(c1_reg[4:1]))
    else $error("overlay palette wrong");
  ovl_uline_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    MODE == OCAR_OVL |=> !UNDERLINE_ON)
    else $error("underline outside caption mode");
  dot_font_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    MODE == OCAR_CDOT |=> !FONT_INDEX[8])
    else $error("dot font high bit set");
  dot_bg_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    MODE == OCAR_CDOT |=> BG_PALETTE == PAL_TRANSPARENT)
    else $error("dot background not cleared");
  dot_zero_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    MODE == OCAR_CDOT && DOT_PAL == PAL_TRANSPARENT |=>
      CHAR_PALETTE == $past(c1_reg[6:3]))
    else $error("dot palette 0 not replaced");
  dot_keep_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    MODE == OCAR_CDOT && DOT_PAL != PAL_TRANSPARENT && DOT_PAL != PAL_BLACK |=>
      CHAR_PALETTE == $past(DOT_PAL))
    else $error("dot palette not kept");
  black_mark_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    BLACK |-> !TRANSPARENT && CHAR_PALETTE == PAL_BLACK)
    else $error("black flag wrong");
  first_lum_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    FIRST_LUMINANCE_OUTPUT != TRANSPARENT)
    else $error("first luminance disagrees with transparency");

  ////////////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////////////
  hole_error_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    setup_ph && in_range && sel == SEL_HOLE |-> ##2 PREADY && PSLVERR)
    else $error("hole access not refused");
  ready_lat_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    setup_ph |-> !PREADY ##1 !PREADY ##1 PREADY)
    else $error("ready latency wrong");
  second_lum_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    c1_reg[C1_LUM2] |=> SECOND_LUMINANCE_OUTPUT)
    else $error("second luminance not driven");
  lum_off_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    !c1_reg[C1_LUM2] |=> !SECOND_LUMINANCE_OUTPUT)
    else $error("second luminance not released");
  ovl_font_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    MODE == OCAR_OVL |=> FONT_INDEX == $past({c1_reg[0], code_reg}))
    else $error("font index wrong");
  cc_pal_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    MODE == OCAR_CC |=> CHAR_PALETTE == $past({CC_PAL_HIGH, c1_reg[3:1]}))
    else $error("caption palette wrong");
  ovl_bg_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    MODE == OCAR_OVL |=> BG_PALETTE == $past({c2_reg[1:0], c1_reg[6:5]}))
    else $error("overlay background wrong");
  uline_row_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    UNDERLINE_ON |-> $past(ROW_SEL) == 5'h16 || $past(ROW_SEL) == 5'h17)
    else $error("underline on wrong row");
  dot_black_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    MODE == OCAR_CDOT && DOT_PAL == 4'h8 |=> CHAR_PALETTE == $past(c1_reg[6:3]))
    else $error("dot palette not replaced");
  flash_italic_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    MODE != OCAR_CC |=> !FLASH && !ITALIC)
    else $error("flash outside caption mode");
  transparent_mark_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    TRANSPARENT |-> !BLACK && CHAR_PALETTE == 4'h0)
    else $error("transparent flag wrong");
endmodule : ocar_top
`default_nettype wire

// ---- verif/ocar_crt.sv ----
// Partner model: video side scan position driver
`timescale 1ns/1ns
`default_nettype none
module ocar_crt (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requested scan position
  input wire logic [2:0] blk,
  input wire logic [4:0] chr,
  input wire logic [4:0] row,
  // Position toward the memory
  output logic [2:0] block_sel,
  output logic [4:0] char_sel,
  output logic [4:0] row_sel,
  output logic settled
);
  logic [3:0] hold_reg; // Cycles the position has stood
  //////////////////////////////////////////////////////////////////////
  // Latch a new position and restart the count; fetch needs 4 cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      block_sel <= 3'h0;
      char_sel <= 5'h0;
      row_sel <= 5'h0;
      hold_reg <= 4'h0;
    end else if ({blk, chr, row} != {block_sel, char_sel, row_sel}) begin
      block_sel <= blk;
      char_sel <= chr;
      row_sel <= row;
      hold_reg <= 4'h0;
    end else if (hold_reg != 4'hf) begin
      hold_reg <= hold_reg + 4'h1;
    end
  end
  // Margin beyond fetch for the output register
  assign settled = (hold_reg >= 4'h8);
endmodule : ocar_crt
`default_nettype wire

// ---- verif/overlay_char_attribute_ram_tb.sv ----
// Testbench for the overlay character attribute memory
`timescale 1ns/1ns
`default_nettype none
module overlay_char_attribute_ram_tb;
  import ocar_pkg::*;
  logic CLOCK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CC_PAL_HIGH, settled, err;
  logic [31:0] PADDR, PWDATA, PRDATA, rd;
  logic [1:0] MODE, CC_BG_RANGE;
  logic [3:0] DOT_PAL, CHAR_PALETTE, BG_PALETTE;
  logic [2:0] BLOCK_SEL, blk;
  logic [4:0] CHAR_SEL, ROW_SEL, chr, row;
  logic [8:0] FONT_INDEX;
  logic ITALIC, FLASH, UNDERLINE_ON, TRANSPARENT, BLACK;
  logic FIRST_LUMINANCE_OUTPUT, SECOND_LUMINANCE_OUTPUT;
  int err_total, cmp_count, cyc;
  ocar_top i_ocar_top (.CLOCK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY,
    .PSLVERR, .PRDATA, .MODE, .BLOCK_SEL, .CHAR_SEL, .ROW_SEL, .DOT_PAL, .CC_PAL_HIGH,
    .CC_BG_RANGE, .FONT_INDEX, .CHAR_PALETTE, .BG_PALETTE, .ITALIC, .FLASH, .UNDERLINE_ON,
    .TRANSPARENT, .BLACK, .FIRST_LUMINANCE_OUTPUT, .SECOND_LUMINANCE_OUTPUT);
  ocar_crt i_ocar_crt (.clk(CLOCK), .rst_n(RSTN), .blk, .chr, .row, .block_sel(BLOCK_SEL),
    .char_sel(CHAR_SEL), .row_sel(ROW_SEL), .settled);
  //////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One APB transfer; waits for PREADY at a rising edge
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    check("pready", PREADY, 1'b1);
  endtask : apb
  function automatic logic [31:0] adr(input int b, input int c, input int s);
    return 32'hd00 + b * 32'h80 + s * 32'h20 + c;
  endfunction : adr
  // Code, first and second color byte of one character
  task wr_ent(input int b, input int c, input logic [7:0] v0, v1, v2);
    logic [7:0] v[3];
    v = '{v0, v1, v2};
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, adr(b, c, s), {24'h0, v[s]});
      check("write err", err, 1'b0);
    end
  endtask : wr_ent
  task show(input int b, input int c, input int r);
    int n;
    blk <= b[2:0];
    chr <= c[4:0];
    row <= r[4:0];
    repeat (8) @(posedge CLOCK);
    n = 0;
    while (settled !== 1'b1 && n < 50) begin
      @(posedge CLOCK);
      n++;
    end
  endtask : show
  task chk(input logic [8:0] fi, input logic [3:0] cp, bp, input logic [6:0] f);
    check("font", FONT_INDEX, fi);
    check("char pal", CHAR_PALETTE, cp);
    check("bg pal", BG_PALETTE, bp);
    check("flags", {ITALIC, FLASH, UNDERLINE_ON, SECOND_LUMINANCE_OUTPUT,
      FIRST_LUMINANCE_OUTPUT, TRANSPARENT, BLACK}, f);
  endtask : chk
  task wrap_up;
    $display("Compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [3:0] dp[3];
    logic [3:0] ep[3];
    dp = '{4'h0, 4'h8, 4'h3};
    ep = '{4'h6, 4'h6, 4'h3};
    {RSTN, PSEL, PENABLE, PWRITE, PADDR, PWDATA, CC_PAL_HIGH, CC_BG_RANGE} = '0;
    {DOT_PAL, blk, chr, row, err_total, cmp_count, cyc} = '0;
    // Reserved mode keeps decode idle while memory still holds unknowns
    MODE = 2'b10;
    repeat (16) @(posedge CLOCK);
    check("rst flags", {ITALIC, FLASH, UNDERLINE_ON, TRANSPARENT, BLACK}, 5'b00010);
    check("rst ready", {PREADY, PSLVERR}, 2'b00);
    RSTN <= 1'b1;
    // Map corners and readback, color2 compared on its two used bits only
    wr_ent(0, 0, 8'h5a, 8'hc3, 8'hfd);
    wr_ent(5, 31, 8'ha7, 8'h3c, 8'h02);
    apb(1'b0, adr(0, 0, 0), 32'h0);
    check("code rd", rd, 32'h5a);
    apb(1'b0, adr(0, 0, 1), 32'h0);
    check("color1 rd", rd, 32'hc3);
    apb(1'b0, adr(0, 0, 2), 32'h0);
    check("color2 rd", rd[1:0], 2'h1);
    apb(1'b0, 32'hf9f, 32'h0);
    check("last code rd", rd, 32'ha7);
    apb(1'b0, 32'hfbf, 32'h0);
    check("last color1 rd", rd, 32'h3c);
    $display("Test map done");
    // Holes and outside addresses refused, nothing corrupted
    apb(1'b1, 32'hd60, 32'hee);
    check("hole wr err", err, 1'b1);
    apb(1'b0, 32'hd7f, 32'h0);
    check("hole rd err", err, 1'b1);
    check("hole rd data", rd, 32'h0);
    apb(1'b0, 32'hc5f, 32'h0);
    check("below rd err", err, 1'b1);
    apb(1'b1, 32'h1000, 32'h11);
    check("above wr err", err, 1'b1);
    apb(1'b0, adr(0, 0, 0), 32'h0);
    check("code kept", rd, 32'h5a);
    $display("Test holes done");
    // Caption mode attributes
    MODE <= OCAR_CC;
    CC_PAL_HIGH <= 1'b1;
    CC_BG_RANGE <= 2'h1;
    wr_ent(2, 5, 8'ha5, 8'hdb, 8'h02);
    show(2, 5, ULINE_ROW_A);
    chk(9'h1a5, 4'hd, 4'h6, 7'b1011100);
    show(2, 5, ULINE_ROW_B);
    check("uline row b", UNDERLINE_ON, 1'b1);
    show(2, 5, 0);
    check("uline row 0", UNDERLINE_ON, 1'b0);
    CC_PAL_HIGH <= 1'b0;
    CC_BG_RANGE <= 2'h3;
    wr_ent(2, 6, 8'h10, 8'h20, 8'h01);
    show(2, 6, ULINE_ROW_A);
    chk(9'h010, 4'h0, 4'hd, 7'b0100010);
    $display("Test caption done");
    // Overlay mode palettes
    MODE <= OCAR_OVL;
    wr_ent(3, 0, 8'hfe, 8'h30, 8'h03);
    show(3, 0, 0);
    chk(9'h0fe, 4'h8, 4'hd, 7'b0000101);
    wr_ent(3, 1, 8'h01, 8'hc3, 8'h00);
    show(3, 1, 0);
    chk(9'h101, 4'h1, 4'h2, 7'b0001100);
    $display("Test overlay done");
    // Color-dot mode, dot palettes 0 and 8 replaced
    MODE <= OCAR_CDOT;
    wr_ent(4, 7, 8'h21, 8'h31, 8'h00);
    for (int i = 0; i < 3; i++) begin
      DOT_PAL <= dp[i];
      show(4, 7, 0);
      check("dot font", FONT_INDEX, 9'h021);
      check("dot pal", CHAR_PALETTE, ep[i]);
      check("dot lum2", SECOND_LUMINANCE_OUTPUT, 1'b0);
    end
    $display("Test color dot done");
    // Reserved mode code draws nothing but the font index and the second luminance bit
    MODE <= 2'b10;
    show(4, 7, 0);
    check("rsv pal", {CHAR_PALETTE, BG_PALETTE, BLACK}, 9'h000);
    check("rsv flags", {ITALIC, FLASH, UNDERLINE_ON, TRANSPARENT}, 4'h1);
    check("rsv lum1", FIRST_LUMINANCE_OUTPUT, 1'b0);
    $display("Test reserved done");
    wrap_up();
  end
endmodule : overlay_char_attribute_ram_tb
`default_nettype wire
